/* hw/psl_consts.svh */
/*
  word counts, addresses and reset values shared by both ends of
  the frame-synchronous parameter update link.
  assumes a 125 mhz core clock and a one-cycle frame tick input.
*/
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// ----------------------------------------------------------------
// staging area locations in parameter memory
// ----------------------------------------------------------------
`define PSL_SLOT0_ADDR      16'h6000
`define PSL_SLOT_LAST_ADDR  16'h6004
`define PSL_TARGET_ADDR     16'h6005
`define PSL_COUNT_ADDR      16'h6006

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define PSL_MAX_WORDS       3'h5
`define PSL_MIN_WORDS       3'h1
`define PSL_ADDR_RST        16'h0000
`define PSL_DATA_RST        32'h0000_0000

`endif

/* hw/psl_pkg.sv */
/*
  types shared by both ends of the parameter update link.
  assumes nothing beyond the constants header.
*/
package psl_pkg;
  typedef logic [15:0] psl_addr_t;  // parameter memory address
  typedef logic [31:0] psl_data_t;  // parameter word
  typedef logic [2:0]  psl_cnt_t;   // word count 0..5
endpackage

/* hw/psl_if.sv */
/*
  control-port link between host and update engine.
  assumes both ends share clk_in and rst_in.
*/
`timescale 1ns/1ps
`default_nettype none
interface psl_if;
  logic                wr_en;    // one-cycle host write strobe
  psl_pkg::psl_addr_t  wr_addr;  // host write address
  psl_pkg::psl_data_t  wr_data;  // host write data
  logic                busy;     // transfer armed or copying

  modport dev  (input wr_en, input wr_addr, input wr_data,
                output busy);
  modport host (output wr_en, output wr_addr, output wr_data,
                input busy);
endinterface
`default_nettype wire

/* hw/psl_device.sv */
/*
  parameter update engine: holds five staging slots, a target address
  and a count; a count write in idle arms a burst copied at the next frame tick.
  assumes frame_tick_in is a one-cycle pulse on clk_in and that the
  parameter ram accepts one write per cycle with no back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.svh"
module psl_device
(
  input  wire logic               clk_in,        // core clock
  input  wire logic               rst_in,        // sync reset, high
  input  wire logic               frame_tick_in, // audio frame start
  psl_if.dev                      link,          // host control port
  output logic                    pram_we_out,   // parameter ram write
  output psl_pkg::psl_addr_t      pram_addr_out, // ram address
  output psl_pkg::psl_data_t      pram_data_out  // ram data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PSL_IDLE  = 3'b001,  // nothing pending
    PSL_ARMED = 3'b010,  // waiting for frame tick
    PSL_COPY  = 3'b100   // streaming words out
  } psl_state_t;

  psl_state_t          state_ff;
  psl_state_t          nxt_state;
  psl_pkg::psl_data_t  slot_ff [0:4];   // staging slots
  psl_pkg::psl_addr_t  target_ff;       // first destination
  psl_pkg::psl_cnt_t   count_ff;        // words requested
  psl_pkg::psl_cnt_t   idx_ff;          // word being copied
  logic                we_ff;
  psl_pkg::psl_addr_t  addr_ff;
  psl_pkg::psl_data_t  data_ff;
  logic                busy_ff;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_target = link.wr_en &&
                          link.wr_addr == `PSL_TARGET_ADDR;
  wire logic hit_count  = link.wr_en &&
                          link.wr_addr == `PSL_COUNT_ADDR;
  wire logic last_word  = idx_ff == count_ff - 3'h1;
  // a zero count would stretch the burst to eight words, so clamp to one..five
  wire psl_pkg::psl_cnt_t clamp_cnt =
    (link.wr_data[2:0] == 3'h0) ? `PSL_MIN_WORDS :
    (link.wr_data[2:0] >  `PSL_MAX_WORDS) ? `PSL_MAX_WORDS :
    link.wr_data[2:0];

  // ----------------------------------------------------------------
  // staging slots, one per generate lane
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_slot
      // slot writes while copying are the host's fault; accepted anyway
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          slot_ff[g] <= `PSL_DATA_RST;
        else if (link.wr_en &&
                 link.wr_addr == `PSL_SLOT0_ADDR + 16'(g))
          slot_ff[g] <= link.wr_data;
      end
    end
  endgenerate

  // target and count registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      target_ff <= `PSL_ADDR_RST;
      count_ff  <= 3'h0;
    end
    else
    begin
      if (hit_target)
        target_ff <= link.wr_data[15:0];
      if (hit_count && state_ff == PSL_IDLE)
        count_ff <= clamp_cnt;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      PSL_IDLE:
        if (hit_count)
          nxt_state = PSL_ARMED;
      PSL_ARMED:
        if (frame_tick_in)
          nxt_state = PSL_COPY;
      PSL_COPY:
        if (last_word)
          nxt_state = PSL_IDLE;
      default:
        nxt_state = PSL_IDLE;
    endcase
  end

  // state and word index; five cycles is far inside any frame
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= PSL_IDLE;
      idx_ff   <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      // stop at the last word so the slot read never leaves 0..4
      if (state_ff == PSL_COPY && !last_word)
        idx_ff <= idx_ff + 3'h1;
      else
        idx_ff <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // registered ram write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      we_ff   <= 1'b0;
      addr_ff <= `PSL_ADDR_RST;
      data_ff <= `PSL_DATA_RST;
      busy_ff <= 1'b0;
    end
    else
    begin
      we_ff   <= state_ff == PSL_COPY;
      addr_ff <= target_ff + 16'(idx_ff);
      data_ff <= slot_ff[idx_ff];
      busy_ff <= nxt_state != PSL_IDLE;
    end
  end

  assign pram_we_out   = we_ff;
  assign pram_addr_out = addr_ff;
  assign pram_data_out = data_ff;
  assign link.busy     = busy_ff;

endmodule // psl_device
`default_nettype wire

/* hw/psl_host.sv */
/*
  host end: takes a request of up to five words and writes slots,
  target and count in order, then waits a frame before accepting more.
  assumes frame_tick_in is the same one-cycle tick the device sees.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.svh"
module psl_host
(
  input  wire logic               clk_in,       // core clock
  input  wire logic               rst_in,       // sync reset, high
  input  wire logic               frame_tick_in,// audio frame start
  input  wire logic               req_in,       // start an update
  input  wire psl_pkg::psl_addr_t target_in,    // destination
  input  wire psl_pkg::psl_cnt_t  count_in,     // words, 1..5
  input  wire psl_pkg::psl_data_t word_in [0:4],// words to send
  output logic                    ready_out,    // may take a request
  psl_if.host                     link          // control port
);

  typedef enum logic [3:0]
  {
    PSH_IDLE  = 4'b0001,  // waiting for request
    PSH_DATA  = 4'b0010,  // writing slots
    PSH_TAIL  = 4'b0100,  // target then count
    PSH_WAIT  = 4'b1000   // frame wait after trigger
  } psh_state_t;

  psh_state_t          state_ff;
  psl_pkg::psl_cnt_t   cnt_ff;     // clamped request size
  psl_pkg::psl_cnt_t   idx_ff;     // slot or tail step
  psl_pkg::psl_addr_t  tgt_ff;
  psl_pkg::psl_data_t  word_ff [0:4];
  logic                en_ff;
  psl_pkg::psl_addr_t  addr_ff;
  psl_pkg::psl_data_t  data_ff;
  logic [1:0]          ticks_ff;   // frame ticks seen since trigger
  logic                rdy_ff;

  // keep the count legal whatever the user asks for
  wire psl_pkg::psl_cnt_t req_cnt =
    (count_in == 3'h0) ? `PSL_MIN_WORDS :
    (count_in > `PSL_MAX_WORDS) ? `PSL_MAX_WORDS : count_in;

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= PSH_IDLE;
      cnt_ff   <= 3'h0;
      idx_ff   <= 3'h0;
      tgt_ff   <= `PSL_ADDR_RST;
      en_ff    <= 1'b0;
      addr_ff  <= `PSL_ADDR_RST;
      data_ff  <= `PSL_DATA_RST;
      ticks_ff <= 2'h0;
      rdy_ff   <= 1'b0;
      for (int i = 0; i < 5; i++)
        word_ff[i] <= `PSL_DATA_RST;
    end
    else
    begin
      en_ff <= 1'b0;
      unique case (state_ff)
        PSH_IDLE:
          begin
            rdy_ff <= ~req_in;
            // idle after reset or after a full frame wait
            if (req_in)
            begin
              cnt_ff   <= req_cnt;
              tgt_ff   <= target_in;
              word_ff  <= word_in;
              idx_ff   <= 3'h0;
              state_ff <= PSH_DATA;
            end
          end
        PSH_DATA:
          begin
            en_ff   <= 1'b1;
            addr_ff <= `PSL_SLOT0_ADDR + 16'(idx_ff);
            data_ff <= word_ff[idx_ff];
            if (idx_ff == cnt_ff - 3'h1)
            begin
              idx_ff   <= 3'h0;
              state_ff <= PSH_TAIL;
            end
            else
              idx_ff <= idx_ff + 3'h1;
          end
        PSH_TAIL:
          begin
            en_ff <= 1'b1;
            if (idx_ff == 3'h0)
            begin
              addr_ff <= `PSL_TARGET_ADDR;
              data_ff <= {16'h0000, tgt_ff};
              idx_ff  <= 3'h1;
            end
            else
            begin
              addr_ff  <= `PSL_COUNT_ADDR;
              data_ff  <= {29'h0000_0000, cnt_ff};
              ticks_ff <= 2'h0;
              state_ff <= PSH_WAIT;
            end
          end
        PSH_WAIT:
          begin
            // two ticks: one to start the copy, one full frame after
            if (frame_tick_in)
              ticks_ff <= ticks_ff + 2'h1;
            if (ticks_ff == 2'h2 && !link.busy)
            begin
              rdy_ff   <= 1'b1;
              state_ff <= PSH_IDLE;
            end
          end
        default:
          state_ff <= PSH_IDLE;
      endcase
    end
  end

  assign ready_out    = rdy_ff;
  assign link.wr_en   = en_ff;
  assign link.wr_addr = addr_ff;
  assign link.wr_data = data_ff;

endmodule // psl_host
`default_nettype wire

/* test/psl_checker.sv */
/*
  concurrent checks on the host-device link and the ram write port.
  assumes one clock, synchronous high reset and a one-cycle frame tick.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.svh"
module psl_checker
(
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               frame_tick_in,
  input wire logic               wr_en,
  input wire psl_pkg::psl_addr_t wr_addr,
  input wire psl_pkg::psl_data_t wr_data,
  input wire logic               busy,
  input wire logic               pram_we_out,
  input wire psl_pkg::psl_addr_t pram_addr_out,
  input wire psl_pkg::psl_data_t pram_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic               we_q_ff;   // ram strobe one cycle back
  psl_pkg::psl_addr_t tgt_ff;    // last target written
  logic [1:0]         rises_ff;  // bursts since last tick
  logic [1:0]         tks_ff;    // ticks since last trigger, saturating
  wire logic          trig = wr_en && wr_addr == `PSL_COUNT_ADDR;
  wire logic          rise = pram_we_out && !we_q_ff;
  // counters instead of long repetitions keep the tools fast
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      we_q_ff <= 1'b0;
      tgt_ff <= 16'h0000;
      rises_ff <= 2'h0;
      tks_ff <= 2'h3;
    end
    else
    begin
      we_q_ff <= pram_we_out;
      if (wr_en && wr_addr == `PSL_TARGET_ADDR)
        tgt_ff <= wr_data[15:0];
      rises_ff <= frame_tick_in ? 2'h0 :
                  rises_ff + {1'b0, rise && rises_ff != 2'h3};
      tks_ff <= trig ? 2'h0 :
                tks_ff + {1'b0, frame_tick_in && tks_ff != 2'h3};
    end
  end
  // ------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------
  chk_first_target: assert property ($rose(pram_we_out) |->
    pram_addr_out == tgt_ff) else $error("burst misses target");
  chk_addr_step: assert property (pram_we_out && $past(pram_we_out) |->
    pram_addr_out == $past(pram_addr_out) + 16'h0001)
    else $error("address not stepped by one");
  chk_copy_on_tick: assert property ($rose(pram_we_out) |->
    $past(frame_tick_in, 2)) else $error("copy not tied to tick");
  chk_arm_busy: assert property (trig && !busy |=> busy)
    else $error("count write did not arm");
  chk_one_burst: assert property (rises_ff <= 2'h1)
    else $error("two bursts in one frame");
  chk_trig_gap: assert property (trig |-> tks_ff >= 2'h2)
    else $error("triggers too close");
  chk_count_last: assert property (trig |-> $past(wr_en) &&
    $past(wr_addr) == `PSL_TARGET_ADDR) else $error("count not after target");
  chk_burst_len: assert property (pram_we_out [*5] |=> !pram_we_out)
    else $error("burst longer than five");
  cover property (pram_we_out [*5]);
  cover property (trig && !busy);
  cover property (trig && busy);
endmodule // psl_checker
`default_nettype wire

/* test/tb_parameter_safeload.sv */
/*
  self-checking bench: host and device on one link, plus a second
  device fed directly with faulty host traffic.
  assumes the design files under hw/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_parameter_safeload;
  logic               clk_in, rst_in, tick, req, rdy, we_a, we_b;
  psl_pkg::psl_addr_t tgt, ad_a, ad_b;
  psl_pkg::psl_cnt_t  cnt;
  psl_pkg::psl_data_t words [0:4];
  psl_pkg::psl_data_t da_a, da_b;
  logic [47:0]        qa [$];  // expected writes, host pair
  logic [47:0]        qb [$];  // expected writes, faulty host
  int                 fails, n_checks, cyc, fcnt, c;
  psl_if lk_a();
  psl_if lk_b();
  psl_host psl_host_inst (.clk_in(clk_in), .rst_in(rst_in),
    .frame_tick_in(tick), .req_in(req), .target_in(tgt),
    .count_in(cnt), .word_in(words), .ready_out(rdy), .link(lk_a));
  psl_device psl_device_inst (.clk_in(clk_in), .rst_in(rst_in),
    .frame_tick_in(tick), .link(lk_a), .pram_we_out(we_a),
    .pram_addr_out(ad_a), .pram_data_out(da_a));
  psl_device psl_device_inst_b (.clk_in(clk_in), .rst_in(rst_in),
    .frame_tick_in(tick), .link(lk_b), .pram_we_out(we_b),
    .pram_addr_out(ad_b), .pram_data_out(da_b));
  psl_checker psl_checker_inst (.clk_in(clk_in), .rst_in(rst_in),
    .frame_tick_in(tick), .wr_en(lk_a.wr_en), .wr_addr(lk_a.wr_addr),
    .wr_data(lk_a.wr_data), .busy(lk_a.busy), .pram_we_out(we_a),
    .pram_addr_out(ad_a), .pram_data_out(da_a));
  // ------------------------------------------------------------
  // clock, frame tick every 40 cycles, hang limit
  // ------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    #1;
    fcnt = (fcnt == 39) ? 0 : fcnt + 1;
    tick = (fcnt == 0);
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // every ram write must match the head of the expected queue;
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge clk_in)
  begin
    if (we_a === 1'b1) cmp({ad_a, da_a}, qa);
    if (we_b === 1'b1) cmp({ad_b, da_b}, qb);
  end
  task automatic cmp(input logic [47:0] got, ref logic [47:0] q [$]);
    n_checks++;
    if (q.size() == 0 || got !== q[0])
    begin
      fails++;
      $display("mismatch at %0t: ram write %h", $time, got);
    end
    if (q.size() != 0) q.delete(0);
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  // one update; extra asks again while busy, which must be ignored
  task automatic send(input int n, input bit extra);
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < 500)
    begin
      step();
      i++;
    end
    tgt = psl_pkg::psl_addr_t'($urandom);
    cnt = psl_pkg::psl_cnt_t'(n);
    for (i = 0; i < 5; i++) words[i] = $urandom;
    for (i = 0; i < n; i++)
      qa.push_back({tgt + psl_pkg::psl_addr_t'(i), words[i]});
    req = 1'b1;
    step();
    req = 1'b0;
    if (extra)
    begin
      repeat (3) step();
      req = 1'b1;
      step();
      req = 1'b0;
    end
  endtask
  // raw link write; caller lowers the strobe after the last one
  task automatic wr(input psl_pkg::psl_addr_t a, input logic [31:0] d);
    lk_b.wr_en = 1'b1;
    lk_b.wr_addr = a;
    lk_b.wr_data = d;
    step();
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'ha2b4));
    rst_in = 1'b1;
    {req, tgt, cnt} = '0;
    words = '{default: 32'h0000_0000};
    {lk_b.wr_en, lk_b.wr_addr, lk_b.wr_data} = '0;
    repeat (5) step();
    rst_in = 1'b0;
    for (c = 0; c < 12; c++)
    begin
      send((c < 5) ? c + 1 : 1 + $urandom % 5, c[0]);
      $display("test %0d done", c);
    end
    wr(16'h6000, 32'h0bad_0001);
    wr(16'h6001, 32'h0bad_0002);
    wr(16'h6005, 32'h0000_0123);
    wr(16'h6006, 32'h0000_0002);
    wr(16'h6006, 32'h0000_0005);
    wr(16'h6007, 32'hffff_ffff);
    lk_b.wr_en = 1'b0;
    qb.push_back({16'h0123, 32'h0bad_0001});
    qb.push_back({16'h0124, 32'h0bad_0002});
    repeat (100) step();
    wr(16'h6000, 32'h5a5a_0003);
    wr(16'h6005, 32'h0000_0200);
    wr(16'h6006, 32'h0000_0000);
    lk_b.wr_en = 1'b0;
    qb.push_back({16'h0200, 32'h5a5a_0003});
    $display("test faulty host done");
    repeat (120) step();
    n_checks++;
    if (qa.size() != 0 || qb.size() != 0)
    begin
      fails++;
      $display("mismatch at %0t: words not copied", $time);
    end
    report_and_stop();
  end
endmodule // tb_parameter_safeload
`default_nettype wire
